// ---- rtl/sar_readout.sv ----
// Conversion start and serial readout logic of the 12-bit converter
`timescale 1ns/1ns
module sar_readout
(
  input  wire logic                          clk,                // System clock, 125 MHz
  input  wire logic                          sys_rst,            // Async reset, active high
  input  wire logic                          conversion_start_n, // Start pin, active low
  input  wire logic                          cs_n,               // Chip select, active low
  input  wire logic                          sclk,               // Serial read clock pin
  input  wire logic [sar_pkg::WORD_BITS-1:0] sar_code_i,         // Code from the analog core
  output logic                               sdo_o,              // Serial data output level
  output logic                               sdo_oe,             // Serial data output enable
  output logic                               hold_o,             // Track-and-hold in hold
  output logic                               pwr_down_o          // Analog core powered down
);
  import sar_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic start_s, cs_s, sclk_s;
  logic start_prev_ff, cs_prev_ff, sclk_prev_ff;

  // Each synchroniser resets to its pin's idle level: no false edge after reset
  sar_sync2 u_sync_start (.clk(clk), .sys_rst(sys_rst), .rst_val(1'b1),
                          .din(conversion_start_n), .dout(start_s));
  sar_sync2 u_sync_cs    (.clk(clk), .sys_rst(sys_rst), .rst_val(1'b1),
                          .din(cs_n), .dout(cs_s));
  sar_sync2 u_sync_sclk  (.clk(clk), .sys_rst(sys_rst), .rst_val(1'b0),
                          .din(sclk), .dout(sclk_s));

  function automatic logic fell(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction : fell

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      start_prev_ff <= 1'b1;
      cs_prev_ff    <= 1'b1;
      sclk_prev_ff  <= 1'b0;
    end
    else
    begin
      start_prev_ff <= start_s;
      cs_prev_ff    <= cs_s;
      sclk_prev_ff  <= sclk_s;
    end
  end

  logic start_fall, cs_fall, sclk_fall, conv_end;
  assign start_fall = fell(start_prev_ff, start_s);
  assign cs_fall    = fell(cs_prev_ff, cs_s);
  assign sclk_fall  = fell(sclk_prev_ff, sclk_s);

  // ----------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------
  sar_state_t                state_ff;
  logic [CONV_CNT_W-1:0]     conv_cnt_ff;
  logic                      hold_ff;
  logic                      pwr_down_ff;
  logic [WORD_BITS-1:0]      result_ff;

  assign conv_end = (state_ff == SAR_CONV) && (conv_cnt_ff == CONV_ZERO);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      conv_cnt_ff <= CONV_ZERO;
      hold_ff     <= 1'b0;
    end
    else if (start_fall && state_ff != SAR_CONV)
    begin
      conv_cnt_ff <= CONV_LOAD;
      hold_ff     <= 1'b1;
    end
    else if (conv_end)
    begin
      hold_ff <= 1'b0;
    end
    else if (state_ff == SAR_CONV)
    begin
      conv_cnt_ff <= conv_cnt_ff - CONV_STEP;
    end
  end

  // Code is latched unchanged: straight binary, code zero at bottom
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      result_ff <= RESULT_RST;
    else if (conv_end)
      result_ff <= sar_code_i;
  end

  // Start still low at conversion end powers the core down; start rising wakes it
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pwr_down_ff <= 1'b0;
    else if (conv_end && !start_s)
      pwr_down_ff <= 1'b1;
    else if (start_s)
      pwr_down_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Readout sequencer
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] shift_ff;
  logic [BIT_CNT_W-1:0] bit_cnt_ff;
  logic                 sdo_ff;
  logic                 sdo_oe_ff;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff   <= SAR_IDLE;
      shift_ff   <= RESULT_RST;
      bit_cnt_ff <= BIT_CNT_RST;
      sdo_ff     <= 1'b0;
      sdo_oe_ff  <= 1'b0;
    end
    else if (start_fall && state_ff != SAR_CONV)
    begin
      state_ff  <= SAR_CONV;
      sdo_oe_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        SAR_CONV:
          if (conv_end)
          begin
            if (!cs_s)
            begin
              state_ff   <= SAR_SHIFT;
              shift_ff   <= sar_code_i;
              sdo_ff     <= sar_code_i[MSB_IDX];
              sdo_oe_ff  <= 1'b1;
              bit_cnt_ff <= BIT_CNT_RST;
            end
            else
              state_ff <= SAR_READY;
          end
        SAR_READY:
          if (cs_fall)
          begin
            state_ff   <= SAR_SHIFT;
            shift_ff   <= result_ff;
            sdo_ff     <= result_ff[MSB_IDX];
            sdo_oe_ff  <= 1'b1;
            bit_cnt_ff <= BIT_CNT_RST;
          end
        SAR_SHIFT:
          if (cs_s)
          begin
            state_ff   <= SAR_IDLE;
            sdo_oe_ff  <= 1'b0;
            bit_cnt_ff <= BIT_CNT_RST;
          end
          else if (sclk_fall)
          begin
            if (bit_cnt_ff == LAST_BIT)
            begin
              state_ff  <= SAR_DONE;
              sdo_oe_ff <= 1'b0;
            end
            else
            begin
              shift_ff   <= {shift_ff[MSB_IDX-1:0], 1'b0};
              sdo_ff     <= shift_ff[MSB_IDX-1];
              bit_cnt_ff <= bit_cnt_ff + BIT_STEP;
            end
          end
        SAR_DONE:
          if (cs_s)
          begin
            state_ff   <= SAR_IDLE;
            bit_cnt_ff <= BIT_CNT_RST;
          end
        default:
          state_ff <= SAR_IDLE;
      endcase
    end
  end

  assign sdo_o      = sdo_ff;
  assign sdo_oe     = sdo_oe_ff;
  assign hold_o     = hold_ff;
  assign pwr_down_o = pwr_down_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam int CONV_DLY = CONV_CYCLES;
  localparam int EOC_DLY  = EOC_SDO_CYC;
  localparam int CS_DLY   = CS_SDO_CYC;
  localparam int HIZ_DLY  = SDO_HIZ_CYC;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_start_hold;
    start_fall && state_ff != SAR_CONV |=> hold_ff && state_ff == SAR_CONV;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start edge missed");

  property p_conv_len;
    $rose(hold_ff) |-> ##CONV_DLY $fell(hold_ff);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_cs_high_off;
    cs_s && state_ff == SAR_SHIFT && !start_fall |=> !sdo_oe_ff && state_ff == SAR_IDLE;
  endproperty
  a_cs_high_off: assert property (p_cs_high_off) else $error("output on while deselected");

  property p_shift_bit;
    state_ff == SAR_SHIFT && !cs_s && sclk_fall && bit_cnt_ff != LAST_BIT && !start_fall
      |=> sdo_oe_ff && sdo_ff == $past(shift_ff[MSB_IDX-1]);
  endproperty
  a_shift_bit: assert property (p_shift_bit) else $error("wrong bit shifted");

  property p_busy_release;
    conv_end && !cs_s |-> ##[1:EOC_DLY] (sdo_oe_ff && sdo_ff == $past(sar_code_i[MSB_IDX]));
  endproperty
  a_busy_release: assert property (p_busy_release) else $error("no busy release");

  property p_cs_start;
    state_ff == SAR_READY && cs_fall && !start_fall
      |-> ##[1:CS_DLY] (sdo_oe_ff && sdo_ff == result_ff[MSB_IDX]);
  endproperty
  a_cs_start: assert property (p_cs_start) else $error("select fall not answered");

  property p_word_end;
    state_ff == SAR_SHIFT && !cs_s && sclk_fall && bit_cnt_ff == LAST_BIT && !start_fall
      |-> ##[1:HIZ_DLY] !sdo_oe_ff;
  endproperty
  a_word_end: assert property (p_word_end) else $error("output not released");

  property p_code;
    conv_end |=> result_ff == $past(sar_code_i);
  endproperty
  a_code: assert property (p_code) else $error("result not latched");

  property p_ignore_sclk;
    state_ff == SAR_IDLE || state_ff == SAR_DONE || (state_ff == SAR_READY && !cs_fall)
      |=> $stable(shift_ff);
  endproperty
  a_ignore_sclk: assert property (p_ignore_sclk) else $error("shift while not selected");

  c_busy_read:  cover property (conv_end && !cs_s);
  c_plain_read: cover property (state_ff == SAR_READY && cs_fall);
  c_word_done:  cover property (state_ff == SAR_SHIFT ##1 state_ff == SAR_DONE);
  c_pwr_down:   cover property ($rose(pwr_down_ff));

endmodule : sar_readout

// ---- shared/sar_pkg.sv ----
// Constants and types shared by the converter readout block
package sar_pkg;

  // ----------------------------------------------------------------
  // Word format
  // ----------------------------------------------------------------
  localparam int unsigned WORD_BITS = 12;
  localparam int unsigned MSB_IDX   = WORD_BITS - 1;
  localparam int unsigned BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT    = 4'hb;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 4'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_STEP    = 4'h1;
  localparam logic [WORD_BITS-1:0] RESULT_RST  = 12'h000;

  // ----------------------------------------------------------------
  // Timing, clock at 125 MHz
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CONV_TIME_NS  = 650;
  localparam int unsigned EOC_SDO_NS    = 8;
  localparam int unsigned CS_SDO_NS     = 18;
  localparam int unsigned SDO_HIZ_NS    = 15;

  function automatic int unsigned max_cyc(input int unsigned ns);
    int unsigned c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : max_cyc

  localparam int unsigned CONV_CYCLES = max_cyc(CONV_TIME_NS);
  localparam int unsigned EOC_SDO_CYC = max_cyc(EOC_SDO_NS);
  localparam int unsigned CS_SDO_CYC  = max_cyc(CS_SDO_NS);
  localparam int unsigned SDO_HIZ_CYC = max_cyc(SDO_HIZ_NS);

  localparam int unsigned CONV_CNT_W = 7;
  localparam logic [CONV_CNT_W-1:0] CONV_LOAD = CONV_CNT_W'(CONV_CYCLES - 1);
  localparam logic [CONV_CNT_W-1:0] CONV_ZERO = 7'h00;
  localparam logic [CONV_CNT_W-1:0] CONV_STEP = 7'h01;

  // ----------------------------------------------------------------
  // Readout sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    SAR_IDLE  = 5'h01,
    SAR_CONV  = 5'h02,
    SAR_READY = 5'h04,
    SAR_SHIFT = 5'h08,
    SAR_DONE  = 5'h10
  } sar_state_t;

endpackage : sar_pkg

// ---- rtl/sar_sync2.sv ----
// Two-stage synchroniser for one pin input
`timescale 1ns/1ns
module sar_sync2 (
  input  wire logic clk,      // System clock
  input  wire logic sys_rst,  // Asynchronous reset, active high
  input  wire logic rst_val,  // Level shown on dout while in reset
  input  wire logic din,      // Pin level from outside the clock domain
  output logic      dout      // Synchronised level
);

  logic stage1_ff;
  logic stage2_ff;
  logic inv;

  // Stages hold the pin level folded with inv, so reset shows rst_val
  // and a pin that idles at that level does not fake an edge
  assign inv = ~rst_val;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage1_ff <= 1'b1;
      stage2_ff <= 1'b1;
    end
    else
    begin
      stage1_ff <= din ^ inv;
      stage2_ff <= stage1_ff;
    end
  end

  assign dout = stage2_ff ^ inv;

endmodule : sar_sync2

// ---- verif/sar_host_model.sv ----
// Host model: drives start, select and burst serial clock, captures the word
`timescale 1ns/1ns
module sar_host_model
(
  input  wire logic                     clk,                // System clock
  input  wire logic                     req,                // Start one transaction
  input  wire logic [1:0]               mode,               // 0 busy, 1 plain, 2 power-down
  input  wire logic                     sdo_line,           // Resolved serial data wire
  output logic                          conversion_start_n, // Conversion start pin
  output logic                          cs_n,               // Select pin
  output logic                          sclk,               // Serial clock pin
  output logic [sar_pkg::WORD_BITS-1:0] word_o,             // Captured word
  output logic                          done_o              // Word captured
);
  import sar_pkg::*;

  // ----------------------------------------------------------------
  // Serial clock half period: 10 cycles, 160 ns period
  // ----------------------------------------------------------------
  localparam int HALF = 10;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  initial
  begin
    conversion_start_n = 1'b1;
    cs_n               = 1'b1;
    sclk               = 1'b0;
    word_o             = '0;
    done_o             = 1'b0;
  end

  always
  begin
    @(posedge clk);
    if (req)
    begin
      conversion_start_n <= 1'b0;
      cs_n               <= (mode != 2'h0);
      if (mode == 2'h2)
      begin
        tick(110);
        conversion_start_n <= 1'b1;
        tick(HALF);
      end
      else
      begin
        tick(4);
        conversion_start_n <= 1'b1;
        // Stray clocks while select is high must be ignored
        repeat ((mode == 2'h1) ? 3 : 0)
        begin
          sclk <= 1'b1;
          tick(HALF);
          sclk <= 1'b0;
          tick(HALF);
        end
        tick((mode == 2'h1) ? 40 : 90);
        cs_n <= 1'b0;
        tick(6);
        for (int k = 0; k < WORD_BITS; k++)
        begin
          sclk              <= 1'b1;
          word_o[MSB_IDX-k] <= sdo_line;
          tick(HALF);
          sclk <= 1'b0;
          tick(HALF);
        end
        tick(HALF);
      end
      done_o <= 1'b1;
      tick(1);
      done_o <= 1'b0;
      cs_n   <= 1'b1;
      tick(HALF);
    end
  end
endmodule : sar_host_model

// ---- verif/sar_adc_serial_readout_tb_top.sv ----
// Self-checking bench for the converter start and serial readout block
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sar_adc_serial_readout_tb_top;
  import sar_pkg::*;
  logic                 clk, sys_rst, req, conv_n, cs_n, sclk, sdo_o, sdo_oe;
  logic                 hold_o, pwr_down_o, done, sdo_line;
  logic [1:0]           mode;
  logic [WORD_BITS-1:0] code, word;
  logic [31:0]          r;
  int                   fail_count, cmp_count, cyc, hl, csh;
  int                   seed = 32'he3d6;
  logic [WORD_BITS-1:0] corner [5] = '{12'h000, 12'hfff, 12'h800, 12'h001, 12'h7ff};

  assign sdo_line = sdo_oe ? sdo_o : 1'b1;

  sar_readout dut (.clk(clk), .sys_rst(sys_rst), .conversion_start_n(conv_n), .cs_n(cs_n),
    .sclk(sclk), .sar_code_i(code), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .hold_o(hold_o),
    .pwr_down_o(pwr_down_o));
  sar_host_model host (.clk(clk), .req(req), .mode(mode), .sdo_line(sdo_line),
    .conversion_start_n(conv_n), .cs_n(cs_n), .sclk(sclk), .word_o(word), .done_o(done));

  always #4 clk = ~clk;

  // ----------------------------------------------------------------
  // Monitors: conversion length, output off while deselected, timeout
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      final_report();
    end
    if (hold_o === 1'b1)
      hl++;
    else if (hl != 0)
    begin
      `CHK(hl, CONV_CYCLES)
      hl = 0;
    end
    csh = (cs_n && !sys_rst) ? csh + 1 : 0;
    if (csh >= 4)
      `CHK(sdo_oe, 1'b0)
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // Busy mode drives the data line as soon as the conversion ends
  function automatic logic exp_busy_oe(input logic [1:0] m);
    return m == 2'h0;
  endfunction : exp_busy_oe

  task automatic run(input logic [1:0] m, input logic [WORD_BITS-1:0] c);
    int n;
    @(posedge clk);
    code <= c;
    req  <= 1'b1;
    mode <= m;
    n = 0;
    // Hold the request until the host has lowered the start pin
    do
    begin
      @(posedge clk);
      n++;
    end
    while (conv_n !== 1'b0 && n < 40);
    req <= 1'b0;
    n = 0;
    while (hold_o !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(hold_o, 1'b1)
    if (m == 2'h2)
    begin
      repeat (90) @(posedge clk);
      `CHK(pwr_down_o, 1'b1)
    end
    else
    begin
      while (hold_o === 1'b1 && n < 200)
      begin
        @(posedge clk);
        n++;
      end
      repeat (2) @(posedge clk);
      `CHK(sdo_oe, exp_busy_oe(m))
    end
    n = 0;
    while (done !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(done, 1'b1)
    if (m == 2'h2)
    begin
      repeat (5) @(posedge clk);
      `CHK(pwr_down_o, 1'b0)
    end
    else
    begin
      `CHK(sdo_oe, 1'b0)
      `CHK(word, c)
    end
  endtask : run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk     = 1'b0;
    sys_rst = 1'b1;
    req     = 1'b0;
    mode    = 2'h0;
    code    = '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    foreach (corner[i])
    begin
      run(2'h0, corner[i]);
      run(2'h1, corner[i]);
    end
    run(2'h2, corner[1]);
    repeat (20)
    begin
      r = $random(seed);
      run({1'b0, r[12]}, r[11:0]);
    end
    r = $random(seed);
    run(2'h2, r[11:0]);
    run(2'h0, r[23:12]);
    final_report();
  end
endmodule : sar_adc_serial_readout_tb_top
